// ===== hw/pic_pkg.sv
// Package of the prioritised interrupt controller: register map, field
// positions, reset values, detection codes, vectors and carrier types.
// Assumes a 32-bit Avalon-MM slave port addressed by word index.
package pic_pkg;

    // ============================================================
    // Sizes
    localparam int NUM_EXT = 8;
    localparam int NUM_SRC = 16;
    localparam int PIN_W = 33;

    // ============================================================
    // Register word indices (byte address is four times the index)
    localparam logic [3:0] REG_SYSCTL = 4'h0;
    localparam logic [3:0] REG_EDGE = 4'h1;
    localparam logic [3:0] REG_LEVEL = 4'h2;
    localparam logic [3:0] REG_ENABLE = 4'h3;
    localparam logic [3:0] REG_KEYMASK = 4'h4;
    localparam logic [3:0] REG_WAKEMASK = 4'h5;
    localparam logic [3:0] REG_DTCSEL = 4'h6;
    localparam logic [3:0] REG_DTCCPU = 4'h7;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_IMASK = 4'h9;
    localparam logic [3:0] REG_PEND = 4'hA;

    // ============================================================
    // Field positions and codes
    localparam int SYS_MODE_LSB = 0;
    localparam int SYS_NMI_RISE = 2;
    localparam logic [1:0] MODE_0 = 2'h0;
    localparam logic [1:0] MODE_1 = 2'h2;
    localparam logic [1:0] DET_LEVEL = 2'h0;
    localparam logic [1:0] DET_FALL = 2'h1;
    localparam logic [1:0] DET_RISE = 2'h2;
    localparam logic [1:0] DET_BOTH = 2'h3;
    localparam int ST_W = 11;
    localparam int ST_NMI = 8;
    localparam int ST_ABRK = 9;
    localparam int ST_DTC = 10;

    // ============================================================
    // Reset values
    localparam logic [2:0] RST_SYSCTL = 3'h0;
    localparam logic [15:0] RST_KEYMASK = 16'hFFFF;
    localparam logic [7:0] RST_WAKEMASK = 8'hFF;
    localparam logic [PIN_W-1:0] RST_PINS = {PIN_W{1'b1}};

    // ============================================================
    // Source codes and vectors
    localparam logic [4:0] SRC_NMI = 5'h10;
    localparam logic [4:0] SRC_ABRK = 5'h11;
    localparam logic [4:0] SRC_NONE = 5'h1F;
    localparam logic [7:0] VEC_NMI = 8'h07;
    localparam logic [7:0] VEC_ABRK = 8'h0F;
    localparam logic [7:0] VEC_BASE = 8'h10;

    // ============================================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic [7:0] vector;
    } pic_req_t;

    typedef enum {AVS_IDLE, AVS_DONE} pic_avs_state_t;

endpackage

// ===== hw/pic_top.sv
// Prioritised interrupt controller, single clock domain.
// Assumes pins arrive asynchronously, core signals are on i_mclk.
//
// Function
// - Two control modes are chosen by a two-bit field of the system control register.
// - Software assigns each maskable source a control level; NMI and address break have none.
// - Every source has its own distinct vector.
// - NMI is highest priority and accepted regardless of masks and levels.
// - NMI detection is selectable rising or falling edge.
// - Each external pin is selectable for falling, rising, both-edge or level detection.
// - Channel six is raised by its pin or any of the low eight key-scan inputs.
// - Channel seven is raised by its pin, the high eight key-scan or any wake-up input.
// - Every key-scan and wake-up input has its own software mask.
// - A request can start a transfer-controller operation instead of or besides the CPU.
// - Mode 1 masks requests by comparing their level with the global and user mask bits.
// - In mode 1 a level-0 request is accepted only while the global mask bit is 0.
// - In mode 1 a level-1 request is accepted while either mask bit is 0.
// - With both mask bits set only NMI and address break are accepted.
// - Mode 1 order is NMI, level-1 sources, address break, then level-0 sources.
`timescale 1ns/10ps
`default_nettype none
module pic_top
    import pic_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // Avalon-MM slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Asynchronous request pins, active low except NMI
    input wire logic i_nmi_pin,
    input wire logic [7:0] i_ext_request_pin_n,
    input wire logic [15:0] i_key_scan_in_n,
    input wire logic [7:0] i_wake_up_in_n,
    // On-chip sources, same clock
    input wire logic [7:0] i_periph_req,
    input wire logic i_addr_break,
    // CPU side
    input wire logic i_global_mask,
    input wire logic i_user_mask_bit,
    input wire logic i_cpu_ack,
    output pic_req_t o_cpu,
    output pic_req_t o_data_transfer_ctrl,
    output logic o_irq
);

    // ============================================================
    // Helper functions
    // Lowest set bit index, SRC_NONE when empty
    function automatic logic [4:0] first_set(input logic [15:0] v);
        logic [4:0] r;
        r = SRC_NONE;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    // One distinct vector per source code
    function automatic logic [7:0] vec_of(input logic [4:0] s);
        logic [7:0] r;
        r = VEC_BASE + {3'h0, s};
        if (s == SRC_NMI) begin
            r = VEC_NMI;
        end else if (s == SRC_ABRK) begin
            r = VEC_ABRK;
        end
        return r;
    endfunction

    // Edge or level detection on an active-low line
    function automatic logic detect(input logic [1:0] code, input logic prev, input logic cur);
        logic r;
        case (code)
            DET_LEVEL: r = ~cur;
            DET_FALL: r = prev & ~cur;
            DET_RISE: r = ~prev & cur;
            default: r = prev ^ cur;
        endcase
        return r;
    endfunction

    // ============================================================
    // Registers
    logic [2:0] sysctl_q;
    logic [15:0] edge_q;
    logic [15:0] level_q;
    logic [15:0] enable_q;
    logic [15:0] keymask_q;
    logic [7:0] wakemask_q;
    logic [15:0] dtcsel_q;
    logic [15:0] dtccpu_q;
    logic [ST_W-1:0] status_q;
    logic [ST_W-1:0] status_d;
    logic [ST_W-1:0] imask_q;
    pic_avs_state_t avs_q;
    logic [PIN_W-1:0] sync1_q, sync2_q, sync3_q, filt_q;
    logic [7:0] comb_prev_q, per_prev_q;
    logic nmi_prev_q;
    logic [7:0] ext_pend_q;
    logic [15:0] dtc_pend_q;
    logic nmi_pend_q, abrk_pend_q;
    logic [4:0] cur_src_q;

    // ============================================================
    // Combinational nets
    logic bus_req, wr_en;
    logic [1:0] mode_sel;
    logic mode1;
    logic [7:0] comb_n, ext_ev, lvl_mode, per_rise;
    logic nmi_ev;
    logic [15:0] route_cpu, cpu_pend, ack_clr, accept0, accept1, src_ev;
    logic ack_nmi, ack_abrk;
    logic [4:0] sel_src, pick0, pick1, dtc_pick;

    assign bus_req = i_avs_read | i_avs_write;
    assign wr_en = i_avs_write & (avs_q == AVS_DONE);
    assign mode_sel = sysctl_q[SYS_MODE_LSB +: 2];
    assign mode1 = (mode_sel == MODE_1);

    // ============================================================
    // Pin synchroniser: three stages, change taken when 2 and 3 agree
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            sync1_q <= RST_PINS;
            sync2_q <= RST_PINS;
            sync3_q <= RST_PINS;
            filt_q <= RST_PINS;
        end else begin
            sync1_q <= {i_wake_up_in_n, i_key_scan_in_n, i_ext_request_pin_n, i_nmi_pin};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q <= (filt_q & (sync2_q ^ sync3_q)) | (sync3_q & ~(sync2_q ^ sync3_q));
        end
    end

    // ============================================================
    // Shared channels; masked inputs are forced inactive
    always_comb begin
        comb_n = filt_q[8:1];
        comb_n[6] = filt_q[7] & (&(filt_q[16:9] | keymask_q[7:0]));
        comb_n[7] = filt_q[8] & (&(filt_q[24:17] | keymask_q[15:8]))
            & (&(filt_q[32:25] | wakemask_q));
    end

    // Detection of external, peripheral and NMI events
    always_comb begin
        for (int i = 0; i < NUM_EXT; i++) begin
            ext_ev[i] = detect(edge_q[2*i +: 2], comb_prev_q[i], comb_n[i]);
            lvl_mode[i] = (edge_q[2*i +: 2] == DET_LEVEL);
        end
        per_rise = i_periph_req & ~per_prev_q;
        nmi_ev = sysctl_q[SYS_NMI_RISE] ? (~nmi_prev_q & filt_q[0]) : (nmi_prev_q & ~filt_q[0]);
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            comb_prev_q <= 8'hFF;
            per_prev_q <= 8'h00;
            nmi_prev_q <= 1'b1;
        end else begin
            comb_prev_q <= comb_n;
            per_prev_q <= i_periph_req;
            nmi_prev_q <= filt_q[0];
        end
    end

    // ============================================================
    // Pending state and acknowledge clearing
    assign src_ev = {per_rise, ext_ev};
    // route: DATA_TRANSFER_CTRL only, CPU only, or both
    assign route_cpu = ~dtcsel_q | dtccpu_q;
    assign ack_nmi = i_cpu_ack & o_cpu.valid & (cur_src_q == SRC_NMI);
    assign ack_abrk = i_cpu_ack & o_cpu.valid & (cur_src_q == SRC_ABRK);
    always_comb begin
        ack_clr = 16'h0000;
        if (i_cpu_ack && o_cpu.valid && !cur_src_q[4]) begin
            ack_clr[cur_src_q[3:0]] = 1'b1;
        end
        // Level sources follow the line; an ack masks them only in its own cycle
        cpu_pend = {i_periph_req, (lvl_mode & ~comb_n) | (~lvl_mode & ext_pend_q)};
        cpu_pend = cpu_pend & route_cpu & enable_q & ~ack_clr;
    end

    // Set wins over ack clear
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            ext_pend_q <= 8'h00;
            nmi_pend_q <= 1'b0;
            abrk_pend_q <= 1'b0;
        end else begin
            // A start handed only to the transfer controller drops its CPU flag
            ext_pend_q <= (ext_pend_q & ~ack_clr[7:0] & route_cpu[7:0]) | (ext_ev & ~lvl_mode);
            nmi_pend_q <= (nmi_pend_q & ~ack_nmi) | nmi_ev;
            abrk_pend_q <= (abrk_pend_q & ~ack_abrk) | i_addr_break;
        end
    end

    // ============================================================
    // Transfer-controller starts, lowest source first
    assign dtc_pick = first_set(dtc_pend_q);
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            dtc_pend_q <= 16'h0000;
            o_data_transfer_ctrl <= '0;
        end else begin
            dtc_pend_q <= (dtc_pend_q & ~(16'h0001 << dtc_pick[3:0] & {16{~dtc_pick[4]}}))
                | (src_ev & dtcsel_q & enable_q);
            o_data_transfer_ctrl.valid <= ~dtc_pick[4];
            o_data_transfer_ctrl.vector <= dtc_pick[4] ? 8'h00 : vec_of(dtc_pick);
        end
    end

    // ============================================================
    // Acceptance and priority
    always_comb begin
        // level 1 open while either bit clear
        accept1 = (mode1 && !(i_global_mask && i_user_mask_bit)) ? (cpu_pend & level_q) : 16'h0;
        // level 0 open only while global bit clear
        accept0 = i_global_mask ? 16'h0000 : (cpu_pend & (mode1 ? ~level_q : 16'hFFFF));
        pick1 = first_set(accept1);
        pick0 = first_set(accept0);
        // both bits set leave only NMI and break
        if (nmi_pend_q && !ack_nmi) begin
            sel_src = SRC_NMI;
        end else if (!pick1[4]) begin
            sel_src = pick1;
        end else if (abrk_pend_q && !ack_abrk) begin
            sel_src = SRC_ABRK;
        end else begin
            sel_src = pick0;
        end
    end

    // Presented request, one source at a time
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            cur_src_q <= SRC_NONE;
            o_cpu <= '0;
        end else begin
            cur_src_q <= sel_src;
            o_cpu.valid <= (sel_src != SRC_NONE);
            o_cpu.vector <= (sel_src == SRC_NONE) ? 8'h00 : vec_of(sel_src);
        end
    end

    // ============================================================
    // Avalon slave: one wait cycle, answer in the cycle after
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            avs_q <= AVS_IDLE;
            o_avs_waitrequest <= 1'b1;
        end else begin
            case (avs_q)
                AVS_IDLE: begin
                    if (bus_req) begin
                        avs_q <= AVS_DONE;
                        o_avs_waitrequest <= 1'b0;
                    end
                end
                AVS_DONE: begin
                    avs_q <= AVS_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
                default: begin
                    avs_q <= AVS_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Read data captured ahead of the answer edge
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_avs_read && avs_q == AVS_IDLE) begin
            case (i_avs_address)
                REG_SYSCTL: o_avs_readdata <= {29'h0, sysctl_q};
                REG_EDGE: o_avs_readdata <= {16'h0, edge_q};
                REG_LEVEL: o_avs_readdata <= {16'h0, level_q};
                REG_ENABLE: o_avs_readdata <= {16'h0, enable_q};
                REG_KEYMASK: o_avs_readdata <= {16'h0, keymask_q};
                REG_WAKEMASK: o_avs_readdata <= {24'h0, wakemask_q};
                REG_DTCSEL: o_avs_readdata <= {16'h0, dtcsel_q};
                REG_DTCCPU: o_avs_readdata <= {16'h0, dtccpu_q};
                REG_STATUS: o_avs_readdata <= {21'h0, status_q};
                REG_IMASK: o_avs_readdata <= {21'h0, imask_q};
                REG_PEND: o_avs_readdata <= {8'h0, o_cpu.vector, cpu_pend};
                default: o_avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Control registers, written at the answer edge
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            sysctl_q <= RST_SYSCTL;
            edge_q <= 16'h0000;
            level_q <= 16'h0000;
            enable_q <= 16'h0000;
            keymask_q <= RST_KEYMASK;
            wakemask_q <= RST_WAKEMASK;
            dtcsel_q <= 16'h0000;
            dtccpu_q <= 16'h0000;
            imask_q <= '0;
        end else if (wr_en) begin
            case (i_avs_address)
                REG_SYSCTL: sysctl_q <= i_avs_writedata[2:0];
                REG_EDGE: edge_q <= i_avs_writedata[15:0];
                REG_LEVEL: level_q <= i_avs_writedata[15:0];
                REG_ENABLE: enable_q <= i_avs_writedata[15:0];
                REG_KEYMASK: keymask_q <= i_avs_writedata[15:0];
                REG_WAKEMASK: wakemask_q <= i_avs_writedata[7:0];
                REG_DTCSEL: dtcsel_q <= i_avs_writedata[15:0];
                REG_DTCCPU: dtccpu_q <= i_avs_writedata[15:0];
                REG_IMASK: imask_q <= i_avs_writedata[ST_W-1:0];
                default: imask_q <= imask_q;
            endcase
        end
    end

    // ============================================================
    // Sticky status, write one to clear, new event wins
    always_comb begin
        status_d = status_q;
        if (wr_en && i_avs_address == REG_STATUS) begin
            status_d = status_q & ~i_avs_writedata[ST_W-1:0];
        end
        status_d[7:0] = status_d[7:0] | (ext_ev & enable_q[7:0]);
        status_d[ST_NMI] = status_d[ST_NMI] | nmi_ev;
        status_d[ST_ABRK] = status_d[ST_ABRK] | i_addr_break;
        status_d[ST_DTC] = status_d[ST_DTC] | ~dtc_pick[4];
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            status_q <= '0;
            o_irq <= 1'b0;
        end else begin
            status_q <= status_d;
            o_irq <= |(status_q & imask_q);
        end
    end

    // ============================================================
    // Assertions
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_bus_taken;
        bus_req && o_avs_waitrequest && avs_q == AVS_IDLE;
    endsequence
    sequence s_bus_answer;
        ##1 !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence

    property p_bus_answer;
        s_bus_taken |-> s_bus_answer;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer not in one cycle");

    property p_nmi_first;
        nmi_pend_q && !ack_nmi |=> o_cpu.valid && o_cpu.vector == VEC_NMI;
    endproperty
    a_nmi_first: assert property (p_nmi_first) else $error("nmi not presented");

    property p_nmi_edge;
        sysctl_q[SYS_NMI_RISE] && !nmi_prev_q && filt_q[0] |=> nmi_pend_q;
    endproperty
    a_nmi_edge: assert property (p_nmi_edge) else $error("nmi rise lost");

    property p_fall_latch;
        edge_q[1:0] == DET_FALL && comb_prev_q[0] && !comb_n[0] |=> ext_pend_q[0];
    endproperty
    a_fall_latch: assert property (p_fall_latch) else $error("falling edge lost");

    property p_key_masked;
        keymask_q[7:0] == 8'hFF && filt_q[7] |-> comb_n[6];
    endproperty
    a_key_masked: assert property (p_key_masked) else $error("masked key raised ch6");

    property p_both_masks;
        mode1 && i_global_mask && i_user_mask_bit
            |=> !o_cpu.valid || o_cpu.vector == VEC_NMI || o_cpu.vector == VEC_ABRK;
    endproperty
    a_both_masks: assert property (p_both_masks) else $error("masked source taken");

    property p_lvl0_held;
        mode1 && i_global_mask && sel_src != SRC_NONE && !sel_src[4] |-> level_q[sel_src[3:0]];
    endproperty
    a_lvl0_held: assert property (p_lvl0_held) else $error("level 0 taken while masked");

    property p_lvl1_before_break;
        mode1 && accept1 != 16'h0000 && !nmi_pend_q |=> o_cpu.valid && o_cpu.vector != VEC_ABRK;
    endproperty
    a_lvl1_before_break: assert property (p_lvl1_before_break) else $error("order wrong");

    property p_dtc_start;
        dtc_pend_q != 16'h0000 |=> o_data_transfer_ctrl.valid ##1 status_q[ST_DTC];
    endproperty
    a_dtc_start: assert property (p_dtc_start) else $error("transfer not started");

    property p_irq;
        (status_q & imask_q) != '0 |=> o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt output missing");

endmodule
`default_nettype wire

// ===== testbench/pic_cpu_model.sv
// CPU side of the interrupt controller: takes the presented request.
// Assumes the request struct of pic_pkg and one clock with the design.
`timescale 1ns/10ps
`default_nettype none
module pic_cpu_model
    import pic_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // Presented request and pacing
    input wire pic_req_t i_cpu,
    input wire logic i_hold,
    input wire logic [1:0] i_delay,
    // Take pulse
    output logic o_cpu_ack
);
    // ============================================================
    // Ack after i_delay cycles; one idle cycle after each pulse
    logic [1:0] wait_q;

    // Hold lets several sources pile up so the winner order shows
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || o_cpu_ack || i_cpu.valid !== 1'b1 || i_hold) begin
            o_cpu_ack <= 1'b0;
            wait_q <= 2'h0;
        end else if (wait_q == i_delay) begin
            o_cpu_ack <= 1'b1;
        end else begin
            wait_q <= wait_q + 2'h1;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/prioritised_interrupt_controller_bench.sv
// Self-checking bench of the interrupt controller.
// Assumes pic_top and pic_cpu_model; one 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module prioritised_interrupt_controller_bench
    import pic_pkg::*;
;
    // ============================================================
    // Signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0;
    logic nmi = 1'b1;
    logic [7:0] pin_n = 8'hFF;
    logic [15:0] key_n = 16'hFFFF;
    logic [7:0] wake_n = 8'hFF;
    logic abrk = 1'b0;
    logic [7:0] per = 8'h00;
    logic gm = 1'b0;
    logic um = 1'b0;
    logic hold = 1'b0;
    logic [1:0] dly = 2'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic irq;
    logic ack;
    pic_req_t cpu;
    pic_req_t data_transfer_ctrl;
    logic [31:0] rq[$];
    logic [31:0] vq[$];
    logic [31:0] dq[$];
    logic [31:0] rnd;
    int fails = 0;
    int n_compared = 0;

    always #5 clk = ~clk;

    pic_top dut (.i_mclk(clk), .i_reset_n(rst_n), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq), .i_nmi_pin(nmi), .i_ext_request_pin_n(pin_n),
        .i_key_scan_in_n(key_n), .i_wake_up_in_n(wake_n), .i_periph_req(per),
        .i_addr_break(abrk), .i_global_mask(gm), .i_user_mask_bit(um), .i_cpu_ack(ack),
        .o_cpu(cpu), .o_data_transfer_ctrl(data_transfer_ctrl), .o_irq(irq));

    pic_cpu_model cpu_side (.i_mclk(clk), .i_reset_n(rst_n), .i_cpu(cpu), .i_hold(hold),
        .i_delay(dly), .o_cpu_ack(ack));

    // ============================================================
    // Comparison and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Avalon master: hold everything until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (waitreq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rdx(input logic [3:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // Bounded wait until every noted result has been seen
    task automatic drain();
        for (int i = 0; i < 300 && (vq.size() + dq.size()) > 0; i++) @(posedge clk);
        check(vq.size() + dq.size(), 32'h0);
    endtask

    task automatic no_cpu();
        repeat (20) @(posedge clk);
        check({31'h0, cpu.valid}, 32'h0);
    endtask

    task automatic brk();
        @(posedge clk);
        abrk <= 1'b1;
        @(posedge clk);
        abrk <= 1'b0;
    endtask

    // Watcher: oldest note against each result as it appears
    always @(posedge clk) begin
        if (rd && waitreq === 1'b0) check(rdata, rq.size() ? rq.pop_front() : 32'hBAD);
        if (ack && cpu.valid === 1'b1) check(cpu.vector, vq.size() ? vq.pop_front() : 32'hBAD);
        if (data_transfer_ctrl.valid === 1'b1) check(data_transfer_ctrl.vector, dq.size() ? dq.pop_front() : 32'hBAD);
    end

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #200us;
        fails++;
        final_report();
    end

    // ============================================================
    // Tests
    initial begin
        void'($urandom(28441));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        dly <= 2'($urandom % 4);
        // Reset values, unmapped word, random level readback
        rdx(REG_KEYMASK, {16'h0, RST_KEYMASK});
        rdx(REG_WAKEMASK, {24'h0, RST_WAKEMASK});
        rdx(REG_SYSCTL, 32'h0);
        rdx(4'hB, 32'h0);
        rnd = $urandom;
        bus(1'b1, REG_LEVEL, rnd);
        rdx(REG_LEVEL, {16'h0, rnd[15:0]});
        $display("test registers done");
        // Mode 0 ignores levels, so the global mask bit blocks every maskable source; mode 1 honours levels
        bus(1'b1, REG_EDGE, 32'h5555);
        bus(1'b1, REG_LEVEL, 32'h000C);
        bus(1'b1, REG_ENABLE, 32'h00FF);
        gm <= 1'b1;
        pin_n <= 8'hFB;
        no_cpu();
        vq.push_back(32'h12);
        bus(1'b1, REG_SYSCTL, {30'h0, MODE_1});
        drain();
        pin_n <= 8'hFF;
        um <= 1'b1;
        repeat (8) @(posedge clk);
        pin_n <= 8'hF0;
        no_cpu();
        vq.push_back(32'h12);
        vq.push_back(32'h13);
        um <= 1'b0;
        drain();
        vq.push_back(32'h10);
        vq.push_back(32'h11);
        gm <= 1'b0;
        drain();
        $display("test masking done");
        // Full mode 1 order with everything pending at once
        pin_n <= 8'hFF;
        hold <= 1'b1;
        repeat (8) @(posedge clk);
        pin_n <= 8'hF0;
        nmi <= 1'b0;
        brk();
        repeat (20) @(posedge clk);
        vq.push_back(32'h07);
        vq.push_back(32'h12);
        vq.push_back(32'h13);
        vq.push_back(32'h0F);
        vq.push_back(32'h10);
        vq.push_back(32'h11);
        hold <= 1'b0;
        drain();
        // NMI on rising edge only; the rise settles before the polarity flips
        nmi <= 1'b1;
        repeat (8) @(posedge clk);
        bus(1'b1, REG_SYSCTL, 32'h6);
        hold <= 1'b1;
        nmi <= 1'b0;
        no_cpu();
        hold <= 1'b0;
        vq.push_back(32'h07);
        nmi <= 1'b1;
        drain();
        $display("test priority done");
        // Key-scan and wake-up sharing, each with its own mask
        pin_n <= 8'hFF;
        bus(1'b1, REG_KEYMASK, 32'hFFFE);
        bus(1'b1, REG_WAKEMASK, 32'h7F);
        key_n <= 16'h0001;
        wake_n <= 8'h80;
        no_cpu();
        vq.push_back(32'h16);
        key_n <= 16'h0000;
        drain();
        vq.push_back(32'h17);
        wake_n <= 8'h00;
        drain();
        key_n <= 16'hFFFF;
        wake_n <= 8'hFF;
        $display("test sharing done");
        // Rise on pin 4, both on pin 5, low level on pin 1
        bus(1'b1, REG_EDGE, 32'h5E51);
        vq.push_back(32'h15);
        pin_n <= 8'hCF;
        drain();
        vq.push_back(32'h14);
        vq.push_back(32'h15);
        pin_n <= 8'hFF;
        drain();
        hold <= 1'b1;
        pin_n <= 8'hFD;
        repeat (20) @(posedge clk);
        check({23'h0, cpu.valid, cpu.vector}, 32'h111);
        pin_n <= 8'hFF;
        no_cpu();
        // Peripheral levels: lowest index wins, each with its own vector
        bus(1'b1, REG_ENABLE, 32'hFFFF);
        per <= 8'hFF;
        repeat (4) @(posedge clk);
        check({23'h0, cpu.valid, cpu.vector}, 32'h118);
        per <= 8'h80;
        repeat (4) @(posedge clk);
        check({23'h0, cpu.valid, cpu.vector}, 32'h11F);
        per <= 8'h00;
        no_cpu();
        hold <= 1'b0;
        $display("test detection done");
        // Transfer start only, then transfer plus CPU
        bus(1'b1, REG_DTCSEL, 32'h1);
        dq.push_back(32'h10);
        pin_n <= 8'hFE;
        no_cpu();
        drain();
        pin_n <= 8'hFF;
        bus(1'b1, REG_DTCCPU, 32'h1);
        dq.push_back(32'h10);
        vq.push_back(32'h10);
        pin_n <= 8'hFE;
        drain();
        $display("test transfer done");
        // Sticky status, mask and the level interrupt
        bus(1'b1, REG_STATUS, 32'h7FF);
        bus(1'b1, REG_IMASK, 32'h0);
        vq.push_back(32'h0F);
        brk();
        drain();
        check({31'h0, irq}, 32'h0);
        rdx(REG_STATUS, 32'h200);
        bus(1'b1, REG_IMASK, 32'h200);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, REG_STATUS, 32'h200);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        $display("test interrupt done");
        final_report();
    end
endmodule
`default_nettype wire
